/* rpl_params.svh */
// Constants for the palette look-up and video level block
`ifndef RPL_PARAMS_SVH
`define RPL_PARAMS_SVH

// Palette geometry
`define RPL_INDEX_W 5
`define RPL_LEVEL_W 4
`define RPL_DEPTH 32
`define RPL_CHANNELS 3

// Level codes
`define RPL_LEVEL_BLACK 4'h0
`define RPL_LEVEL_WHITE 4'hf
`define RPL_LEVEL_BLANKED 4'h0

// Register port
`define RPL_BUS_AW 8
`define RPL_BUS_DW 32
`define RPL_OFS_PROBE_CTRL 8'h00
`define RPL_OFS_STATUS 8'h04
`define RPL_OFS_PROBE_DATA 8'h08
`define RPL_OFS_STROBE_COUNT 8'h0c

// Reset values
`define RPL_RST_PROBE_INDEX 5'h00
`define RPL_RST_STROBE_COUNT 16'h0000

`endif

/* rpl_pkg.sv */
// Types shared by the palette look-up and video level block
package rpl_pkg;

   // Converter register contents with qualifier flags
   typedef struct packed {
      logic blank;
      logic sync;
      logic [3:0] red;
      logic [3:0] green;
      logic [3:0] blue;
   } rpl_video_t;

   // Shared palette access inputs
   typedef struct packed {
      logic [4:0] index;
      logic [3:0] value;
      logic write_mode;
   } rpl_access_t;

   // What the converter registers currently hold
   typedef enum logic [3:0] {
      PH_IDLE = 4'h1,
      PH_ACTIVE = 4'h2,
      PH_BLANK = 4'h4,
      PH_BLACK = 4'h8
   } rpl_phase_t;

endpackage

/* rpl_edge.sv */
// Rise and fall detector for a synchronous input level
`timescale 1ns/1ps
`default_nettype none

module rpl_edge (
   input wire logic clk, // System clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic level, // Level to watch
   output logic rise, // One-cycle pulse on 0 to 1
   output logic fall // One-cycle pulse on 1 to 0
);

   logic prev_reg;

   // Previous level; reset high so a high input does not fake a rise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_reg <= 1'b1;
      end else begin
         prev_reg <= level;
      end
   end

   assign rise = level & ~prev_reg;
   assign fall = ~level & prev_reg;

endmodule

`default_nettype wire

/* rpl_palette.sv */
// One colour channel palette: 32 entries of 4 bits
`timescale 1ns/1ps
`default_nettype none
`include "rpl_params.svh"

module rpl_palette (
   input wire logic clk, // System clock
   input wire logic wr_en, // Write pulse, already qualified by select
   input wire logic [`RPL_INDEX_W-1:0] index, // Shared write and look-up index
   input wire logic [`RPL_LEVEL_W-1:0] wr_value, // Value to store
   input wire logic select_n, // Channel select, active low
   output logic [`RPL_LEVEL_W-1:0] rd_value, // Gated look-up result
   input wire logic [`RPL_INDEX_W-1:0] probe_index, // Software probe index
   output logic [`RPL_LEVEL_W-1:0] probe_value // Raw entry at probe index
);

   // Contents are not reset: they are undefined until written
   logic [`RPL_LEVEL_W-1:0] mem [0:`RPL_DEPTH-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[index] <= wr_value;
      end
   end

   assign rd_value = select_n ? `RPL_LEVEL_BLACK : mem[index];
   assign probe_value = mem[probe_index];

endmodule

`default_nettype wire

/* rpl_top.sv */
// Palette look-up tables feeding strobed triple 4-bit video level registers
//
// Overview of operation
// - Blank and sync together: all levels zero, red/blue blank, green sync; here one shared blank flag and one shared sync flag are set.
// - Read/write select low means display read, high means palette write.
// - Outputs hold the last load until the next strobe edge.
// - Strobe during write mode loads reference black into all channels.
// - The 5-bit index is write location and display colour index.
// - A write stores the value only in selected channel palettes.
// - Each channel has its own active-low select gating read and write.
// - A deselected channel presents zero to its converter input.
// - Deselected channel holds its level until a strobe loads black.
// - Three independent 32 by 4 palettes sharing index, value, mode.
// - Converter inputs come only from their own palette outputs.
// - The write pulse stores the value at the indexed entry.
// - Each strobe loads all three converter registers together.
// - Blanking high clears all registers and blanks every output.
// - Sync high forces only the green output to sync level; here sync_req only sets the shared sync flag and no level changes.
// - After retrace release, normal data loads at the following strobe.
// - Inputs, blanking and sync are sampled on the strobe falling edge.
// - Code 0000 is reference black and 1111 is reference white.
`timescale 1ns/1ps
`default_nettype none
`include "rpl_params.svh"

module rpl_top (
   input wire logic clk, // System clock, 200 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire logic [4:0] palette_index, // Shared palette index
   input wire logic [3:0] palette_write_value, // Shared palette write value
   input wire logic write_mode, // Low read (display), high write
   input wire logic red_palette_select_n, // Red palette select, active low
   input wire logic green_palette_select_n, // Green palette select, active low
   input wire logic blue_palette_select_n, // Blue palette select, active low
   input wire logic strobe, // Converter strobe, loads on falling edge
   input wire logic blank_req, // Synchronous blanking control
   input wire logic sync_req, // Synchronous sync control, sets the shared sync flag only
   input wire logic [7:0] bus_addr, // Register byte address
   input wire logic [31:0] bus_wdata, // Register write data
   input wire logic bus_wr, // Register write strobe
   input wire logic bus_rd, // Register read strobe
   output logic [31:0] bus_rdata, // Register read data, cycle after strobe
   output rpl_pkg::rpl_video_t video_out, // Converter levels with blank and sync flags
   output logic white_level // High while all three levels are white
);

   import rpl_pkg::*;

   // Channel order inside arrays: 0 red, 1 green, 2 blue
   localparam int NCH = `RPL_CHANNELS;

   rpl_access_t access;
   logic [NCH-1:0] select_n;
   logic [3:0] lut_value [0:NCH-1];
   logic [3:0] probe_value [0:NCH-1];
   logic [NCH-1:0] lut_wr;
   logic write_rise;
   logic strobe_fall;

   rpl_video_t video_reg;
   rpl_video_t video_next;
   rpl_phase_t phase_reg;
   rpl_phase_t phase_next;
   logic white_reg;
   logic [4:0] probe_index_reg;
   logic [15:0] strobe_count_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // Match a bus address against a register offset
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   // Bundle the shared palette inputs
   // index shared by both modes
   assign access = '{index: palette_index, value: palette_write_value, write_mode: write_mode};
   assign select_n = {blue_palette_select_n, green_palette_select_n, red_palette_select_n};

   // Write mode is entered by the rising edge of the read/write line
   rpl_edge u_write_edge (
      .clk(clk),
      .rst(rst),
      .level(write_mode),
      .rise(write_rise),
      .fall()
   );

   // Strobe is taken on its high-to-low transition
   // falling strobe sampling
   rpl_edge u_strobe_edge (
      .clk(clk),
      .rst(rst),
      .level(strobe),
      .rise(),
      .fall(strobe_fall)
   );

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch = ch + 1) begin : g_lut
         assign lut_wr[ch] = write_rise & ~select_n[ch];

         rpl_palette u_palette (
            .clk(clk),
            .wr_en(lut_wr[ch]),
            .index(access.index),
            .wr_value(access.value),
            .select_n(select_n[ch]),
            .rd_value(lut_value[ch]),
            .probe_index(probe_index_reg),
            .probe_value(probe_value[ch])
         );
      end
   endgenerate

   // Next converter contents, decided only at a strobe fall
   always_comb begin
      video_next = video_reg;
      phase_next = phase_reg;
      if (strobe_fall) begin
         if (blank_req) begin
            video_next.red = `RPL_LEVEL_BLANKED;
            video_next.green = `RPL_LEVEL_BLANKED;
            video_next.blue = `RPL_LEVEL_BLANKED;
            video_next.blank = 1'b1;
            video_next.sync = sync_req;
            phase_next = PH_BLANK;
         end else if (access.write_mode) begin
            video_next.red = `RPL_LEVEL_BLACK;
            video_next.green = `RPL_LEVEL_BLACK;
            video_next.blue = `RPL_LEVEL_BLACK;
            video_next.blank = 1'b0;
            video_next.sync = sync_req;
            phase_next = PH_BLACK;
         end else begin
            video_next.red = lut_value[0];
            video_next.green = lut_value[1];
            video_next.blue = lut_value[2];
            video_next.blank = 1'b0;
            video_next.sync = sync_req;
            phase_next = PH_ACTIVE;
         end
      end
   end

   // Converter registers; reset stands in for the missing power-up load
   // hold until first strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         video_reg <= '0;
      end else begin
         video_reg <= video_next;
      end
   end

   // Phase of the converter contents, visible in status
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_reg <= PH_IDLE;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // White indication, registered so the output comes from a flip-flop
   // white code
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         white_reg <= 1'b0;
      end else begin
         white_reg <= (video_next.red == `RPL_LEVEL_WHITE)
            && (video_next.green == `RPL_LEVEL_WHITE)
            && (video_next.blue == `RPL_LEVEL_WHITE)
            && !video_next.blank;
      end
   end

   assign video_out = video_reg;
   assign white_level = white_reg;

   // Probe index written by software, steers the palette readback port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         probe_index_reg <= `RPL_RST_PROBE_INDEX;
      end else if (bus_wr && hit(bus_addr, `RPL_OFS_PROBE_CTRL)) begin
         probe_index_reg <= bus_wdata[4:0];
      end
   end

   // Strobe counter; a software write clears it, with a strobe in the same cycle it loads 1
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobe_count_reg <= `RPL_RST_STROBE_COUNT;
      end else if (strobe_fall) begin
         if (bus_wr && hit(bus_addr, `RPL_OFS_STROBE_COUNT)) begin
            strobe_count_reg <= 16'h0001;
         end else begin
            strobe_count_reg <= strobe_count_reg + 16'h0001;
         end
      end else if (bus_wr && hit(bus_addr, `RPL_OFS_STROBE_COUNT)) begin
         strobe_count_reg <= `RPL_RST_STROBE_COUNT;
      end
   end

   // Read mux; the probe path is combinational memory, so it reads live
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit(bus_addr, `RPL_OFS_PROBE_CTRL)) begin
         rdata_next = {27'h0, probe_index_reg};
      end else if (hit(bus_addr, `RPL_OFS_STATUS)) begin
         rdata_next = {14'h0, phase_reg, video_reg.blank, video_reg.sync,
            video_reg.red, video_reg.green, video_reg.blue};
      end else if (hit(bus_addr, `RPL_OFS_PROBE_DATA)) begin
         rdata_next = {20'h0, probe_value[0], probe_value[1], probe_value[2]};
      end else if (hit(bus_addr, `RPL_OFS_STROBE_COUNT)) begin
         rdata_next = {16'h0, strobe_count_reg};
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (bus_rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   assign bus_rdata = rdata_reg;

endmodule

`default_nettype wire

/* rpl_properties.sv */
// Port checks for the palette look-up and video level block
`timescale 1ns/1ps
`default_nettype none

module rpl_properties (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic write_mode, // High for write mode
   input wire logic red_palette_select_n, // Red select, active low
   input wire logic green_palette_select_n, // Green select, active low
   input wire logic blue_palette_select_n, // Blue select, active low
   input wire logic strobe, // Converter strobe
   input wire logic blank_req, // Blanking control
   input wire logic sync_req, // Sync control
   input wire logic bus_rd, // Register read strobe
   input wire logic [31:0] bus_rdata, // Register read data
   input wire rpl_pkg::rpl_video_t video_out, // Levels with flags
   input wire logic white_level // All levels white
);
   import rpl_pkg::*;
   // One clock domain, so clock and reset are stated once
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Levels as one word keeps comparisons short
   wire [11:0] lv = {video_out.red, video_out.green, video_out.blue};

   hold_outputs_a: assert property (!(!strobe && $past(strobe)) |=> $stable(video_out))
      else $error("video changed without a strobe fall");
   blank_clears_a: assert property (!strobe && $past(strobe) && blank_req
      |=> video_out.blank && lv == 12'h000) else $error("blanking did not clear levels");
   write_black_a: assert property (!strobe && $past(strobe) && !blank_req && write_mode
      |=> !video_out.blank && lv == 12'h000) else $error("write mode strobe not black");
   sync_flag_a: assert property (!strobe && $past(strobe)
      |=> video_out.sync == $past(sync_req)) else $error("sync flag wrong after strobe");
   deselect_zero_a: assert property (!strobe && $past(strobe) && !blank_req && !write_mode
      |=> (video_out.red == 4'h0 || !$past(red_palette_select_n))
      && (video_out.green == 4'h0 || !$past(green_palette_select_n))
      && (video_out.blue == 4'h0 || !$past(blue_palette_select_n)))
      else $error("deselected channel not zero");
   resume_data_a: assert property (!strobe && $past(strobe) && !blank_req
      |=> !video_out.blank) else $error("blank flag kept after release");
   white_flag_a: assert property (white_level == (lv == 12'hfff && !video_out.blank))
      else $error("white flag disagrees with levels");
   rdata_idle_a: assert property (!bus_rd |=> bus_rdata == 32'h0)
      else $error("read data outside read cycle");
endmodule

bind rpl_top rpl_properties i_rpl_properties (.clk(clk), .rst(rst), .write_mode(write_mode),
   .red_palette_select_n(red_palette_select_n), .green_palette_select_n(green_palette_select_n),
   .blue_palette_select_n(blue_palette_select_n), .strobe(strobe), .blank_req(blank_req),
   .sync_req(sync_req), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .video_out(video_out),
   .white_level(white_level));
`default_nettype wire

/* rpl_ctrl_model.sv */
// Display controller model driving the pixel and palette inputs
`timescale 1ns/1ps
`default_nettype none

module rpl_ctrl_model (
   input wire logic clk, // System clock
   output logic [4:0] palette_index, // Colour index or write location
   output logic [3:0] palette_write_value, // Palette write value
   output logic write_mode, // High for write mode
   output logic [2:0] sel_n, // Red, green, blue selects, active low
   output logic strobe, // Converter strobe, idles high
   output logic blank_req, // Blanking control
   output logic sync_req // Sync control
);
   // Idle levels; strobe high so no fall is seen at reset release
   initial begin
      palette_index = 5'h00;
      palette_write_value = 4'h0;
      write_mode = 1'b0;
      sel_n = 3'b111;
      strobe = 1'b1;
      blank_req = 1'b0;
      sync_req = 1'b0;
   end
   task automatic write_entry(input int ch, input logic [4:0] idx, input logic [3:0] val);
      @(posedge clk);
      palette_index <= idx;
      palette_write_value <= val;
      sel_n <= ~(3'b100 >> ch);
      @(posedge clk);
      write_mode <= 1'b1;
      @(posedge clk);
      write_mode <= 1'b0;
      sel_n <= 3'b111;
   endtask
   task automatic setup(input logic [4:0] idx, input logic [2:0] s, input logic b, y, w);
      @(posedge clk);
      palette_index <= idx;
      sel_n <= s;
      blank_req <= b;
      sync_req <= y;
      write_mode <= w;
   endtask
   // Falling strobe held one cycle, then back high
   task automatic pulse();
      @(posedge clk);
      strobe <= 1'b0;
      @(posedge clk);
      strobe <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* rpl_top_bench.sv */
// Self-checking bench for the palette look-up and video level block
`timescale 1ns/1ps
`default_nettype none

module rpl_top_bench;
   import rpl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] bus_addr = 8'h00;
   logic [31:0] bus_wdata = 32'h0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [31:0] bus_rdata;
   rpl_video_t video_out;
   logic white_level;
   wire [4:0] idx;
   wire [3:0] val;
   wire [2:0] sel_n;
   wire wm, st, bl, sy;
   int err_count = 0;
   int checks = 0;

   // 200 MHz clock
   always #2.5 clk = ~clk;

   rpl_ctrl_model i_rpl_ctrl_model (.clk(clk), .palette_index(idx), .palette_write_value(val),
      .write_mode(wm), .sel_n(sel_n), .strobe(st), .blank_req(bl), .sync_req(sy));
   rpl_top i_rpl_top (.clk(clk), .rst(rst), .palette_index(idx), .palette_write_value(val),
      .write_mode(wm), .red_palette_select_n(sel_n[2]), .green_palette_select_n(sel_n[1]),
      .blue_palette_select_n(sel_n[0]), .strobe(st), .blank_req(bl), .sync_req(sy),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .video_out(video_out), .white_level(white_level));

   task automatic conclude();
      $display("checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      checks++;
      if (seen !== expd) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, expd);
      end
   endtask
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe, so sample just past that edge
   task automatic bus_read(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 check(bus_rdata, e);
   endtask
   task automatic px(input logic [4:0] i, input logic [2:0] s, input logic b, y, w,
      input logic [13:0] e);
      i_rpl_ctrl_model.setup(i, s, b, y, w);
      i_rpl_ctrl_model.pulse();
      #1 check(32'(video_out), 32'(e));
      $display("test done at %0t", $time);
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 32; i++) begin
         for (int c = 0; c < 3; c++) begin
            i_rpl_ctrl_model.write_entry(c, 5'(i), c == 1 ? ~4'(i) : 4'(i));
         end
      end
      i_rpl_ctrl_model.write_entry(0, 5'd5, 4'h7);
      i_rpl_ctrl_model.write_entry(1, 5'd31, 4'hf);
      #1 check(32'(video_out), 32'h0);
      check(32'(white_level), 32'h0);
      px(5'd5, 3'b000, 1'b0, 1'b0, 1'b0, 14'h07a5);
      px(5'd31, 3'b000, 1'b0, 1'b0, 1'b0, 14'h0fff);
      check(32'(white_level), 32'h1);
      i_rpl_ctrl_model.setup(5'd3, 3'b111, 1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      check(32'(video_out), 32'h0fff);
      px(5'd3, 3'b010, 1'b0, 1'b0, 1'b0, 14'h0303);
      px(5'd31, 3'b000, 1'b0, 1'b0, 1'b1, 14'h0000);
      check(32'(white_level), 32'h0);
      px(5'd3, 3'b000, 1'b1, 1'b0, 1'b0, 14'h2000);
      px(5'd3, 3'b000, 1'b1, 1'b1, 1'b0, 14'h3000);
      px(5'd3, 3'b000, 1'b0, 1'b1, 1'b0, 14'h13c3);
      px(5'd3, 3'b000, 1'b0, 1'b0, 1'b0, 14'h03c3);
      bus_write(8'h0c, 32'h0);
      px(5'd3, 3'b000, 1'b0, 1'b0, 1'b0, 14'h03c3);
      bus_read(8'h0c, 32'h1);
      bus_read(8'h04, 32'h83c3);
      bus_read(8'h10, 32'h0);
      bus_write(8'h00, 32'h5);
      bus_read(8'h08, 32'h07a5);
      conclude();
   end

   // Run needs about 1.7 us; cut a hang well past that
   initial begin
      #20000;
      err_count++;
      conclude();
   end
endmodule
`default_nettype wire
